// ==== src/tai_defines.svh ====
`ifndef TAI_DEFINES_SVH
`define TAI_DEFINES_SVH

// Register byte offsets
`define TAI_OFF_CTRL   8'h00
`define TAI_OFF_MASK   8'h04
`define TAI_OFF_MODE   8'h08
`define TAI_OFF_OVT1   8'h0C
`define TAI_OFF_OVT2   8'h10
`define TAI_OFF_LIM1   8'h14
`define TAI_OFF_LIM2   8'h18
`define TAI_OFF_SDEXT  8'h1C
`define TAI_OFF_STAT   8'h20
`define TAI_OFF_STATE  8'h24

// Field positions
`define TAI_CTRL_SD1     4
`define TAI_CTRL_SD2     5
`define TAI_MASK_SRC1    4
`define TAI_MASK_SRC2    5
`define TAI_MODE_OVT2_EN 3
`define TAI_MODE_SINGLE1 5
`define TAI_MODE_CMP2    6
`define TAI_OVT1_STOP    0
`define TAI_OVT1_MODE    4
`define TAI_OVT1_DIS     6
`define TAI_OVT2_STOP    0
`define TAI_OVT2_MODE    1
`define TAI_OVT2_FLT_LO  3
`define TAI_LIM_HIGH     0
`define TAI_LIM_HYST     8
`define TAI_LIM_SDHI     16
`define TAI_LIM_SDLO     24

// Writable bits
`define TAI_CTRL_WMASK  8'h70
`define TAI_MASK_WMASK  8'h30
`define TAI_MODE_WMASK  8'h68
`define TAI_OVT1_WMASK  8'h51
`define TAI_OVT2_WMASK  8'h1B
`define TAI_SDEXT_WMASK 8'h07

// Reset values
`define TAI_RST_CTRL  8'h00
`define TAI_RST_MASK  8'h00
`define TAI_RST_MODE  8'h00
`define TAI_RST_OVT1  8'h40
`define TAI_RST_OVT2  8'h00
`define TAI_RST_SDEXT 8'h00
`define TAI_RST_LIM   32'h3C5A4B50

// Hysteresis value that selects comparator mode on source one
`define TAI_HYST_CMP  8'h7F

`endif

// ==== src/tai_pkg.sv ====
package tai_pkg;

    typedef enum logic [1:0] {
        TAI_SHUTDOWN = 2'b00,
        TAI_COMPARE  = 2'b01,
        TAI_TWICE    = 2'b10,
        TAI_ONCE     = 2'b11
    } tai_mode_t;

endpackage

// ==== src/tai_alert_logic.sv ====
// How it works
// - CTRL bit 4 puts source one into shutdown interrupt mode.
// - Shutdown mode alerts above shutdown high and below shutdown low, once per excursion.
// - Shutdown rise alerts even while earlier status is still unread.
// - Source one comparator mode: shutdown off and hysteresis limit equals 7F.
// - Source one comparator keeps alerting each sample while above the limit.
// - Source one two-times mode: hysteresis limit other than 7F, single bit zero, shutdown off.
// - Two-times alerts on rise above limit and fall below hysteresis, no repeats.
// - Single-event bit set: source one alerts only on rise, rearms below hysteresis.
// - Reading status clears pending alerts; new events are dropped while pending.
// - Shutdown enables: CTRL bits 5 and 6, SDEXT bits for sources four to six; only CTRL bit 5 acts here, CTRL bit 6 and SDEXT are only stored.
// - Source two comparator select: alert from rise above limit until below hysteresis.
// - Source two comparator select clear gives two-times behaviour.
// - Mask bits block source one and two alerts in non-shutdown modes.
// - OVT1 bit 6 set disables the source one overheat output.
// - OVT1 bit 4 clear: overheat output follows limit with hysteresis.
// - OVT1 bit 4 set: overheat events on rise and on fall, no repeats.
// - In interrupt mode overheat output holds until status is read.
// - Stop bits freeze monitoring of source one and source two.
// - MODE bit 3 enables the source two overheat output.
// - OVT2 bit 1 picks comparator or interrupt for source two overheat.
// - OVT2 bits 4:3 set consecutive faults needed before source two overheat.
// - Each source has limit, hysteresis limit and shutdown limits in LIM registers.
//
// Register access over AHB-Lite and the register offsets were left to the implementer.
`include "tai_defines.svh"

module tai_alert_logic
    import tai_pkg::*;
#(
    parameter int FAULT_W = 2
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Temperature samples from the measurement path
    input wire logic [7:0] source_one_temp,
    input wire logic source_one_sample,
    input wire logic [7:0] source_two_temp,
    input wire logic source_two_sample,
    // Alert pins
    output logic mgmt_alert_n,
    output logic overheat_out_n
);

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] mask;
        logic [7:0] mode;
        logic [7:0] ovt1;
        logic [7:0] ovt2;
        logic [7:0] sdext;
        logic [1:0][31:0] lim;
        logic [1:0] pend;
        logic [1:0] ovt_lat;
        logic [1:0] hot;
        logic [1:0] ovt_hot;
        logic [1:0][FAULT_W-1:0] fault;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic alert_n;
        logic ovt_n;
    } tai_state_t;

    tai_state_t r;
    tai_state_t n;

    tai_mode_t src_mode [2];
    logic [1:0] masked;
    logic [1:0] stopped;
    logic [1:0] ovt_en;
    logic [1:0] ovt_int;
    logic [1:0][FAULT_W-1:0] need;
    logic [1:0][7:0] temp;
    logic [1:0] sample;
    logic addr_ok;
    logic rd_phase;
    logic wr_phase;
    logic stat_read;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = r.rdata;
    assign mgmt_alert_n = r.alert_n;
    assign overheat_out_n = r.ovt_n;

    assign temp[0] = source_one_temp;
    assign temp[1] = source_two_temp;
    assign sample[0] = source_one_sample;
    assign sample[1] = source_two_sample;

    assign addr_ok = (haddr[31:8] == 24'h000000);
    assign rd_phase = hsel && hready && htrans[1] && !hwrite;
    assign wr_phase = hsel && hready && htrans[1] && hwrite && addr_ok;
    // Reading status is what rearms the alert path
    assign stat_read = rd_phase && addr_ok && (haddr[7:0] == `TAI_OFF_STAT);

    // Mode decode per source
    always_comb begin
        if (r.ctrl[`TAI_CTRL_SD1]) begin
            src_mode[0] = TAI_SHUTDOWN;
        end else if (r.lim[0][`TAI_LIM_HYST +: 8] == `TAI_HYST_CMP) begin
            src_mode[0] = TAI_COMPARE;
        end else if (r.mode[`TAI_MODE_SINGLE1]) begin
            src_mode[0] = TAI_ONCE;
        end else begin
            src_mode[0] = TAI_TWICE;
        end
        if (r.ctrl[`TAI_CTRL_SD2]) begin
            src_mode[1] = TAI_SHUTDOWN;
        end else if (r.mode[`TAI_MODE_CMP2]) begin
            src_mode[1] = TAI_COMPARE;
        end else begin
            src_mode[1] = TAI_TWICE;
        end
        masked[0] = r.mask[`TAI_MASK_SRC1];
        masked[1] = r.mask[`TAI_MASK_SRC2];
        stopped[0] = r.ovt1[`TAI_OVT1_STOP];
        stopped[1] = r.ovt2[`TAI_OVT2_STOP];
        ovt_en[0] = !r.ovt1[`TAI_OVT1_DIS];
        ovt_en[1] = r.mode[`TAI_MODE_OVT2_EN];
        ovt_int[0] = r.ovt1[`TAI_OVT1_MODE];
        ovt_int[1] = r.ovt2[`TAI_OVT2_MODE];
        need[0] = '0;
        need[1] = r.ovt2[`TAI_OVT2_FLT_LO +: FAULT_W];
    end

    function automatic logic [31:0] read_word(input tai_state_t s, input logic [7:0] a);
        logic [31:0] w;
        w = 32'h00000000;
        case (a)
            `TAI_OFF_CTRL: w[7:0] = s.ctrl;
            `TAI_OFF_MASK: w[7:0] = s.mask;
            `TAI_OFF_MODE: w[7:0] = s.mode;
            `TAI_OFF_OVT1: w[7:0] = s.ovt1;
            `TAI_OFF_OVT2: w[7:0] = s.ovt2;
            `TAI_OFF_LIM1: w = s.lim[0];
            `TAI_OFF_LIM2: w = s.lim[1];
            `TAI_OFF_SDEXT: w[7:0] = s.sdext;
            `TAI_OFF_STAT: w[3:0] = {s.ovt_lat, s.pend};
            `TAI_OFF_STATE: w[3:0] = {s.ovt_hot, s.hot};
            default: w = 32'h00000000;
        endcase
        return w;
    endfunction

    always_comb begin
        logic [1:0] pend_set;
        logic [1:0] lat_set;
        logic above;
        logic below;
        logic ev;
        logic trip;
        logic [1:0] ovt_out;
        pend_set = 2'b00;
        lat_set = 2'b00;
        above = 1'b0;
        below = 1'b0;
        ev = 1'b0;
        trip = 1'b0;
        ovt_out = 2'b00;
        n = r;

        // Write lands in the data phase; unmapped writes are dropped
        if (r.wr_pend) begin
            case (r.wr_addr)
                `TAI_OFF_CTRL: n.ctrl = hwdata[7:0] & `TAI_CTRL_WMASK;
                `TAI_OFF_MASK: n.mask = hwdata[7:0] & `TAI_MASK_WMASK;
                `TAI_OFF_MODE: n.mode = hwdata[7:0] & `TAI_MODE_WMASK;
                `TAI_OFF_OVT1: n.ovt1 = hwdata[7:0] & `TAI_OVT1_WMASK;
                `TAI_OFF_OVT2: n.ovt2 = hwdata[7:0] & `TAI_OVT2_WMASK;
                `TAI_OFF_LIM1: n.lim[0] = hwdata;
                `TAI_OFF_LIM2: n.lim[1] = hwdata;
                `TAI_OFF_SDEXT: n.sdext = hwdata[7:0] & `TAI_SDEXT_WMASK;
                default: n.ctrl = n.ctrl;
            endcase
        end
        n.wr_pend = wr_phase;
        n.wr_addr = wr_phase ? haddr[7:0] : r.wr_addr;

        for (int i = 0; i < 2; i++) begin
            ev = 1'b0;
            trip = 1'b0;
            above = $signed(temp[i]) > $signed(r.lim[i][`TAI_LIM_HIGH +: 8]);
            below = $signed(temp[i]) < $signed(r.lim[i][`TAI_LIM_HYST +: 8]);
            if (sample[i] && !stopped[i]) begin
                unique case (src_mode[i])
                    TAI_SHUTDOWN: begin
                        if (!r.hot[i] && ($signed(temp[i]) >
                                $signed(r.lim[i][`TAI_LIM_SDHI +: 8]))) begin
                            n.hot[i] = 1'b1;
                            ev = 1'b1;
                        end else if (r.hot[i] && ($signed(temp[i]) <
                                $signed(r.lim[i][`TAI_LIM_SDLO +: 8]))) begin
                            n.hot[i] = 1'b0;
                            ev = 1'b1;
                        end
                    end
                    TAI_COMPARE: begin
                        if (i == 0) begin
                            n.hot[i] = above;
                        end else if (above) begin
                            n.hot[i] = 1'b1;
                        end else if (below) begin
                            n.hot[i] = 1'b0;
                        end
                        ev = n.hot[i];
                    end
                    TAI_TWICE: begin
                        if (!r.hot[i] && above) begin
                            n.hot[i] = 1'b1;
                            ev = 1'b1;
                        end else if (r.hot[i] && below) begin
                            n.hot[i] = 1'b0;
                            ev = 1'b1;
                        end
                    end
                    TAI_ONCE: begin
                        if (!r.hot[i] && above) begin
                            n.hot[i] = 1'b1;
                            ev = 1'b1;
                        end else if (r.hot[i] && below) begin
                            n.hot[i] = 1'b0;
                        end
                    end
                endcase
                // Shutdown rise bypasses the unread-status suppression
                if (ev && (src_mode[i] == TAI_SHUTDOWN)) begin
                    pend_set[i] = 1'b1;
                end else if (ev && !masked[i] && (!r.pend[i] || stat_read)) begin
                    pend_set[i] = 1'b1;
                end

                // Consecutive fault counter, saturating at the threshold
                if (!above) begin
                    n.fault[i] = '0;
                end else if (r.fault[i] == need[i]) begin
                    trip = 1'b1;
                end else begin
                    n.fault[i] = FAULT_W'(r.fault[i] + 1'b1);
                end
                if (!ovt_int[i]) begin
                    if (trip) begin
                        n.ovt_hot[i] = 1'b1;
                    end else if (below) begin
                        n.ovt_hot[i] = 1'b0;
                    end
                end else if (!r.ovt_hot[i] && trip) begin
                    n.ovt_hot[i] = 1'b1;
                    lat_set[i] = 1'b1;
                end else if (r.ovt_hot[i] && below) begin
                    n.ovt_hot[i] = 1'b0;
                    lat_set[i] = 1'b1;
                end
            end
        end

        n.pend = r.pend | pend_set;
        n.ovt_lat = r.ovt_lat | lat_set;
        // Read data reflects this cycle's write and events
        n.rdata = (rd_phase && addr_ok) ? read_word(n, haddr[7:0]) : r.rdata;
        // Set wins over the read-clear so no event is lost
        if (stat_read) begin
            n.pend = pend_set;
            n.ovt_lat = lat_set;
        end

        for (int i = 0; i < 2; i++) begin
            ovt_out[i] = ovt_en[i] && (ovt_int[i] ? n.ovt_lat[i] : n.ovt_hot[i]);
        end
        n.alert_n = !(|n.pend);
        n.ovt_n = !(|ovt_out);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r.ctrl <= `TAI_RST_CTRL;
            r.mask <= `TAI_RST_MASK;
            r.mode <= `TAI_RST_MODE;
            r.ovt1 <= `TAI_RST_OVT1;
            r.ovt2 <= `TAI_RST_OVT2;
            r.sdext <= `TAI_RST_SDEXT;
            r.lim <= {`TAI_RST_LIM, `TAI_RST_LIM};
            r.pend <= 2'b00;
            r.ovt_lat <= 2'b00;
            r.hot <= 2'b00;
            r.ovt_hot <= 2'b00;
            r.fault <= '0;
            r.wr_pend <= 1'b0;
            r.wr_addr <= 8'h00;
            r.rdata <= 32'h00000000;
            r.alert_n <= 1'b1;
            r.ovt_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic quiet;
    assign quiet = !stat_read;

    a_sd_rise_alert: assert property (
        source_one_sample && !stopped[0] && src_mode[0] == TAI_SHUTDOWN && !r.hot[0]
        && ($signed(source_one_temp) > $signed(r.lim[0][`TAI_LIM_SDHI +: 8]))
        |=> !mgmt_alert_n && r.hot[0])
        else $error("shutdown rise did not alert");
    a_sd_mode_sel: assert property (
        r.ctrl[`TAI_CTRL_SD1] |-> src_mode[0] == TAI_SHUTDOWN)
        else $error("shutdown bit ignored");
    a_cmp_mode_sel: assert property (
        !r.ctrl[`TAI_CTRL_SD1] && r.lim[0][`TAI_LIM_HYST +: 8] == `TAI_HYST_CMP
        |-> src_mode[0] == TAI_COMPARE)
        else $error("comparator mode not selected");
    a_cmp_repeat: assert property (
        source_one_sample && !stopped[0] && src_mode[0] == TAI_COMPARE && !r.pend[0]
        && !masked[0] && ($signed(source_one_temp)
        > $signed(r.lim[0][`TAI_LIM_HIGH +: 8])) |=> !mgmt_alert_n)
        else $error("comparator did not realert after read");
    a_status_clear: assert property (
        stat_read && !source_one_sample && !source_two_sample ##1 1'b1
        |-> mgmt_alert_n && r.pend == 2'b00)
        else $error("status read did not clear alert");
    a_once_no_fall: assert property (
        source_one_sample && !stopped[0] && src_mode[0] == TAI_ONCE && r.hot[0]
        && !r.pend[0] |=> !r.pend[0])
        else $error("one-time mode alerted on fall");
    a_mask_blocks: assert property (
        masked[0] && src_mode[0] != TAI_SHUTDOWN && !r.pend[0] |=> !r.pend[0])
        else $error("masked source alerted");
    a_ovt_disabled: assert property (
        r.ovt1[`TAI_OVT1_DIS] && !r.mode[`TAI_MODE_OVT2_EN] && quiet |=> overheat_out_n)
        else $error("disabled overheat output asserted");
    a_ovt_cmp_hold: assert property (
        ovt_en[0] && !ovt_int[0] && r.ovt_hot[0] && $stable(r.ovt1) |-> !overheat_out_n)
        else $error("comparator overheat output released early");
    a_ovt_int_hold: assert property (
        ovt_en[0] && ovt_int[0] && r.ovt_lat[0] && $stable(r.ovt1) |-> !overheat_out_n)
        else $error("interrupt overheat output released before read");
    a_two_cmp_hold: assert property (
        source_two_sample && !stopped[1] && src_mode[1] == TAI_COMPARE && r.hot[1]
        && !masked[1] && !($signed(source_two_temp)
        < $signed(r.lim[1][`TAI_LIM_HYST +: 8])) |=> !mgmt_alert_n)
        else $error("source two comparator alert released early");
    a_stop_freeze: assert property (
        stopped[1] && !r.wr_pend |=> $stable(r.hot[1]) && $stable(r.fault[1]))
        else $error("stopped source changed state");
    a_fault_reset: assert property (
        source_two_sample && !stopped[1] && ($signed(source_two_temp)
        <= $signed(r.lim[1][`TAI_LIM_HIGH +: 8])) |=> r.fault[1] == '0)
        else $error("fault counter not cleared");

    c_sd_alert: cover property (src_mode[0] == TAI_SHUTDOWN ##1 $fell(mgmt_alert_n));
    c_alert_cleared: cover property ($fell(mgmt_alert_n) ##[1:50] $rose(mgmt_alert_n));
    c_ovt_latched: cover property (ovt_int[1] && $fell(overheat_out_n));
    c_fault_trip: cover property (need[1] == 2'd2 && $rose(r.ovt_hot[1]));

endmodule

// ==== verification/tai_chipset_model.sv ====
module tai_chipset_model (
    // Clock
    input wire logic hclk,
    // Alert pins seen by the chipset
    input wire logic mgmt_alert_n,
    input wire logic overheat_out_n,
    // Number of assertions seen on each pin
    output int alert_count = 0,
    output int overheat_count = 0
);
    timeunit 1ns;
    timeprecision 1ns;

    logic alert_q = 1'b1;
    logic ovt_q = 1'b1;

    // Counted on the clock, since the pins are registered and never glitch
    always @(posedge hclk) begin
        if (alert_q && !mgmt_alert_n) begin
            alert_count <= alert_count + 1;
        end
        if (ovt_q && !overheat_out_n) begin
            overheat_count <= overheat_count + 1;
        end
        alert_q <= mgmt_alert_n;
        ovt_q <= overheat_out_n;
    end
endmodule

// ==== verification/tb.sv ====
`include "tai_defines.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import tai_pkg::*;

    logic hclk, hresetn, hsel, hwrite, s1, s2, hot, pend;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0] htrans, r;
    logic [2:0] hsize;
    logic [7:0] t1, t2, tv;
    wire logic hreadyout, hresp, mgmt_alert_n, overheat_out_n;
    wire logic [31:0] hrdata;
    int err_total, n_tests, ac, alert_count, overheat_count;
    tai_mode_t m;
    logic [7:0] offs [10] = '{`TAI_OFF_CTRL, `TAI_OFF_MASK, `TAI_OFF_MODE, `TAI_OFF_OVT1,
        `TAI_OFF_OVT2, `TAI_OFF_LIM1, `TAI_OFF_LIM2, `TAI_OFF_SDEXT, `TAI_OFF_STAT, `TAI_OFF_STATE};
    logic [31:0] rstv [10] = '{32'h0, 32'h0, 32'h0, 32'h40, 32'h0, `TAI_RST_LIM, `TAI_RST_LIM,
        32'h0, 32'h0, 32'h0};
    logic [31:0] wm [10] = '{32'h70, 32'h30, 32'h68, 32'h51, 32'h1B, 32'hFFFFFFFF, 32'hFFFFFFFF,
        32'h07, 32'h0, 32'h0};
    logic [7:0] ftemp [7] = '{8'h60, 8'h60, 8'h00, 8'h60, 8'h60, 8'h60, 8'h40};
    logic fexp [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};

    tai_alert_logic #(.FAULT_W(2)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .source_one_temp(t1), .source_one_sample(s1), .source_two_temp(t2),
        .source_two_sample(s2), .mgmt_alert_n(mgmt_alert_n), .overheat_out_n(overheat_out_n));

    tai_chipset_model pm (.hclk(hclk), .mgmt_alert_n(mgmt_alert_n),
        .overheat_out_n(overheat_out_n), .alert_count(alert_count),
        .overheat_count(overheat_count));

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task end_of_test;
        $display("Comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // One single word transfer; read data lands in rd
    task bus(input logic [31:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'b010;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk({hreadyout, hresp}, 32'h2);
    endtask

    // One-cycle sample strobe; returns once the registered pins have settled
    task smp(input logic two, input logic [7:0] t);
        @(posedge hclk);
        s1 <= !two;
        s2 <= two;
        t1 <= t;
        t2 <= t;
        @(posedge hclk);
        s1 <= 1'b0;
        s2 <= 1'b0;
        #1;
    endtask

    task so(input logic two, input logic [7:0] t, input logic e);
        smp(two, t);
        chk(overheat_out_n, e);
    endtask

    task rst;
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask

    // Returns {event, hot} for source one
    function automatic logic [1:0] ref_step(tai_mode_t md, logic h, logic signed [7:0] t,
        logic signed [7:0] hi, logic signed [7:0] lo);
        case (md)
            TAI_COMPARE: return {t > hi, t > hi};
            TAI_ONCE: return (!h && t > hi) ? 2'b11 : {1'b0, h && !(t < lo)};
            default: begin
                if (!h && t > hi)
                    return 2'b11;
                if (h && t < lo)
                    return 2'b10;
                return {1'b0, h};
            end
        endcase
    endfunction

    initial begin
        #400000;
        err_total++;
        end_of_test;
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        s1 = 1'b0;
        s2 = 1'b0;
        t1 = 8'h00;
        t2 = 8'h00;
        void'($urandom(32'h4A98));
        rst;
        for (int i = 0; i < 10; i++) begin
            bus({24'h0, offs[i]}, 1'b0, 32'h0);
            chk(rd, rstv[i]);
            bus({24'h0, offs[i]}, 1'b1, 32'hFFFFFFFF);
            bus({24'h0, offs[i]}, 1'b0, 32'h0);
            chk(rd, wm[i]);
        end
        bus(32'h100, 1'b1, 32'hFFFFFFFF);
        bus(32'h100, 1'b0, 32'h0);
        chk(rd, 32'h0);
        // Random walk in each source one mode; a reset between modes clears hot state
        for (int k = 0; k < 4; k++) begin
            m = tai_mode_t'(k);
            rst;
            bus(`TAI_OFF_CTRL, 1'b1, (m == TAI_SHUTDOWN) ? 32'h10 : 32'h0);
            bus(`TAI_OFF_MODE, 1'b1, (m == TAI_ONCE) ? 32'h20 : 32'h0);
            bus(`TAI_OFF_LIM1, 1'b1, {8'hE0, 8'h20,
                (m == TAI_COMPARE) ? `TAI_HYST_CMP : 8'hF0, 8'h10});
            hot = 1'b0;
            pend = 1'b0;
            repeat (60) begin
                tv = 8'($urandom());
                smp(1'b0, tv);
                r = (m == TAI_SHUTDOWN) ? ref_step(m, hot, tv, 8'h20, 8'hE0)
                    : ref_step(m, hot, tv, 8'h10, 8'hF0);
                hot = r[0];
                pend = pend | r[1];
                chk(mgmt_alert_n, !pend);
                chk(overheat_out_n, 1'b1);
                if ($urandom_range(3) == 0) begin
                    bus(`TAI_OFF_STAT, 1'b0, 32'h0);
                    chk(rd[0], pend);
                    pend = 1'b0;
                    chk(mgmt_alert_n, 1'b1);
                end
            end
        end
        rst;
        bus(`TAI_OFF_MASK, 1'b1, 32'h10);
        smp(1'b0, 8'h60);
        chk(mgmt_alert_n, 1'b1);
        rst;
        ac = alert_count;
        smp(1'b0, 8'h60);
        bus(`TAI_OFF_STAT, 1'b0, 32'h0);
        smp(1'b0, 8'h70);
        chk(mgmt_alert_n, 1'b1);
        smp(1'b0, 8'h00);
        chk(mgmt_alert_n, 1'b0);
        // The partner counts a fall one clock after the pin drops
        @(posedge hclk);
        #1;
        chk(32'(alert_count - ac), 32'h2);
        // Source one overheat: comparator, then interrupt, disable and stop
        bus(`TAI_OFF_OVT1, 1'b1, 32'h0);
        so(1'b0, 8'h60, 1'b0);
        so(1'b0, 8'h4C, 1'b0);
        so(1'b0, 8'h40, 1'b1);
        bus(`TAI_OFF_OVT1, 1'b1, 32'h10);
        so(1'b0, 8'h60, 1'b0);
        bus(`TAI_OFF_STAT, 1'b0, 32'h0);
        chk(rd[2], 1'b1);
        chk(overheat_out_n, 1'b1);
        so(1'b0, 8'h70, 1'b1);
        so(1'b0, 8'h40, 1'b0);
        bus(`TAI_OFF_STAT, 1'b0, 32'h0);
        chk(overheat_out_n, 1'b1);
        bus(`TAI_OFF_OVT1, 1'b1, 32'h50);
        so(1'b0, 8'h60, 1'b1);
        bus(`TAI_OFF_STAT, 1'b0, 32'h0);
        bus(`TAI_OFF_OVT1, 1'b1, 32'h51);
        so(1'b0, 8'h40, 1'b1);
        chk(mgmt_alert_n, 1'b1);
        // Source two: three consecutive faults needed, a cool sample restarts the count
        rst;
        bus(`TAI_OFF_MODE, 1'b1, 32'h08);
        bus(`TAI_OFF_OVT2, 1'b1, 32'h10);
        ac = overheat_count;
        for (int i = 0; i < 7; i++) begin
            so(1'b1, ftemp[i], fexp[i]);
        end
        chk(32'(overheat_count - ac), 32'h1);
        bus(`TAI_OFF_OVT2, 1'b1, 32'h11);
        for (int i = 0; i < 3; i++) begin
            so(1'b1, 8'h60, 1'b1);
        end
        // Source two comparator alert keeps firing until below hysteresis
        rst;
        bus(`TAI_OFF_MODE, 1'b1, 32'h40);
        smp(1'b1, 8'h60);
        chk(mgmt_alert_n, 1'b0);
        bus(`TAI_OFF_STAT, 1'b0, 32'h0);
        chk(rd[1], 1'b1);
        smp(1'b1, 8'h4C);
        chk(mgmt_alert_n, 1'b0);
        bus(`TAI_OFF_STAT, 1'b0, 32'h0);
        smp(1'b1, 8'h40);
        chk(mgmt_alert_n, 1'b1);
        end_of_test;
    end
endmodule
